// ===== usb_ctl_top.sv
// USB device control and configuration registers with link-side control outputs
//
// Overview of operation
// - Enable activates engine, clears all pointer bits
// - Enable switches on pull-ups when the pull-up bit is set: soft attach
// - Readable single-ended-zero status bit
// - Pointer reset forces even buffers
// - Pointer reset ignored without ping-pong mode
// - SETUP token sets packet disable
// - Packet disable is clear-only from CPU
// - Pending events stay in status FIFO
// - Resume bit drives resume signalling
// - Suspend gates engine clock, low power
// - Suspended: attached, transceiver outputs idle unless the resume bit is set
// - Transceiver enabled with module enable
// - Speed select picks full or low
// - Pull-ups need pull-up bit and enable
// - Config field selects ping-pong mode
// - Eye pattern needs eye bit and enable
// - Eye test repeats J/K sequence forever
// - Status window over four-entry FIFO
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module usb_ctl_top
  import usb_ctl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Engine events
  input  wire logic              setup_token,
  input  wire logic              trn_push,
  input  wire logic [7:0]        trn_status,
  input  wire logic              line_se0,
  input  wire logic              pll_ready,
  // Engine control
  output logic                   engine_en,
  output logic                   engine_clk_en,
  output logic                   packets_en,
  output logic                   trn_fifo_full,
  output logic [NUM_BD-1:0]      pp_pointer,
  input  wire logic [NUM_BD-1:0] pp_toggle,
  // Transceiver
  output logic                   xcvr_en,
  output logic                   xcvr_full_speed,
  output logic                   xcvr_suspend,
  output logic                   pullup_on,
  output logic                   line_drive,
  output logic [1:0]             line_state
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        ctl;       // usb_control_reg image
    logic [7:0]        cfg;       // usb_config_reg image
    logic              trn_done;  // transaction_done_flag
    logic [NUM_BD-1:0] pingpong_pointer_bit;      // Ping-pong pointer bits
    logic [7:0]        rdata;     // Read data, one cycle after strobe
    logic              eng_en;    // Registered outputs below
    logic              clk_en;
    logic              pkt_en;
    logic              fifo_full;
    logic              x_en;
    logic              x_fs;
    logic              x_susp;
    logic              pu;
    logic              drv;
    logic [1:0]        line;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;

  // Child outputs
  logic [7:0] fifo_head;  // Head of status FIFO
  logic       fifo_ne;    // FIFO holds data
  logic       fifo_full;  // FIFO is full
  logic       fifo_pop;   // Firmware cleared the done flag
  logic       eye_k;      // Eye symbol is K
  logic       eye_run;    // Eye test active

  // Decoded controls
  logic enable;
  logic suspend;
  logic pp_mode;

  assign enable  = st_r.ctl[CTL_ENABLE];
  assign suspend = st_r.ctl[CTL_SUSPEND];
  assign pp_mode = (st_r.cfg[CFG_PPB_LSB+1:CFG_PPB_LSB] != PPB_NONE);
  assign eye_run = st_r.cfg[CFG_EYE] && enable && !suspend;

  // Done-flag write of 0 while set advances the FIFO
  // clear advances FIFO
  assign fifo_pop = reg_wr && (reg_addr == ADDR_EVENTS) && !reg_wdata[EVT_TRN] && st_r.trn_done;

  // ------------------------------------------------------------
  // Status FIFO and eye generator
  // ------------------------------------------------------------
  usb_status_fifo u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .push      (trn_push),
    .push_data (trn_status),
    .pop       (fifo_pop),
    .head      (fifo_head),
    .not_empty (fifo_ne),
    .full      (fifo_full)
  );

  usb_eye_gen u_eye (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .run        (eye_run),
    .full_speed (st_r.cfg[CFG_FS]),
    .sym_k      (eye_k)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] rd;
    rd     = 8'h00;
    st_nxt = st_r;

    // SE0 status tracks the line every cycle
    // live line status
    st_nxt.ctl[CTL_SE0] = line_se0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONTROL: begin
          st_nxt.ctl[CTL_PPRST]   = reg_wdata[CTL_PPRST];
          st_nxt.ctl[CTL_ENABLE]  = reg_wdata[CTL_ENABLE];
          st_nxt.ctl[CTL_RESUME]  = reg_wdata[CTL_RESUME];
          st_nxt.ctl[CTL_SUSPEND] = reg_wdata[CTL_SUSPEND];
          if (!reg_wdata[CTL_PACKET_DISABLE_FLAG]) begin
            st_nxt.ctl[CTL_PACKET_DISABLE_FLAG] = 1'b0;
          end
        end
        ADDR_CONFIG: begin
          st_nxt.cfg = reg_wdata & 8'h97;
        end
        ADDR_EVENTS: begin
          if (!reg_wdata[EVT_TRN]) begin
            st_nxt.trn_done = 1'b0;
          end
        end
        default: begin
          st_nxt.rdata = st_nxt.rdata;
        end
      endcase
    end

    // Engine sets; set wins over a simultaneous clear
    // SETUP disables packets
    if (setup_token && enable) begin
      st_nxt.ctl[CTL_PACKET_DISABLE_FLAG] = 1'b1;
    end
    // Done flag set by new data; re-asserts when FIFO still holds more
    // pending events kept
    if ((trn_push && !fifo_full) || (fifo_ne && !fifo_pop && !st_r.trn_done)) begin
      st_nxt.trn_done = 1'b1;
    end else if (fifo_pop && fifo_ne) begin
      st_nxt.trn_done = st_nxt.trn_done;
    end

    // Ping-pong pointers follow the engine, cleared on enable edge
    st_nxt.pingpong_pointer_bit = st_r.pingpong_pointer_bit ^ pp_toggle;
    if (reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[CTL_ENABLE] && !enable) begin
      st_nxt.pingpong_pointer_bit = '0;
    end
    // reset to even only in ping-pong mode
    if (st_r.ctl[CTL_PPRST] && pp_mode) begin
      st_nxt.pingpong_pointer_bit = '0;
    end

    // Read data, valid in the cycle after the strobe only
    case (reg_addr)
      ADDR_CONTROL: rd = st_r.ctl & 8'h7E;
      ADDR_CONFIG:  rd = st_r.cfg;
      ADDR_STATUS:  rd = fifo_head;
      ADDR_EVENTS:  rd = {6'h00, pll_ready, st_r.trn_done};
      default:      rd = 8'h00;
    endcase
    st_nxt.rdata = reg_rd ? rd : 8'h00;

    // Engine controls
    // clock gated while suspended or disabled
    st_nxt.eng_en    = enable;
    st_nxt.clk_en    = enable && !suspend;
    st_nxt.pkt_en    = enable && !st_r.ctl[CTL_PACKET_DISABLE_FLAG];
    st_nxt.fifo_full = fifo_full;
    st_nxt.x_en      = enable;
    st_nxt.x_fs      = st_r.cfg[CFG_FS];
    st_nxt.x_susp    = enable && suspend;
    // pull-ups need both bits, kept during suspend
    st_nxt.pu        = enable && st_r.cfg[CFG_PULLUP];

    // Line driver priority: eye test, then resume, else released
    if (eye_run) begin
      st_nxt.drv  = 1'b1;
      st_nxt.line = eye_k ? LINE_K : LINE_J;
    end else if (enable && st_r.ctl[CTL_RESUME]) begin
      st_nxt.drv  = 1'b1;
      st_nxt.line = LINE_K;
    end else begin
      st_nxt.drv  = 1'b0;
      st_nxt.line = LINE_IDLE;
    end
  end

  // ------------------------------------------------------------
  // Register the state
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r     <= '0;
      st_r.ctl <= CONTROL_RST;
      st_r.cfg <= CONFIG_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata       = st_r.rdata;
  assign engine_en       = st_r.eng_en;
  assign engine_clk_en   = st_r.clk_en;
  assign packets_en      = st_r.pkt_en;
  assign trn_fifo_full   = st_r.fifo_full;
  assign pp_pointer      = st_r.pingpong_pointer_bit;
  assign xcvr_en         = st_r.x_en;
  assign xcvr_full_speed = st_r.x_fs;
  assign xcvr_suspend    = st_r.x_susp;
  assign pullup_on       = st_r.pu;
  assign line_drive      = st_r.drv;
  assign line_state      = st_r.line;

endmodule
`default_nettype wire

// ===== usb_ctl_pkg.sv
// Package: register map, field positions, reset values and timing for the USB control block
package usb_ctl_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;  // usb_control_reg
  localparam logic [3:0] ADDR_CONFIG    = 4'h1;  // usb_config_reg
  localparam logic [3:0] ADDR_STATUS    = 4'h2;  // transfer_status_window
  localparam logic [3:0] ADDR_EVENTS    = 4'h3;  // transaction_done_flag and pll status

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int CTL_PPRST   = 6;  // pingpong_pointer_reset
  localparam int CTL_SE0     = 5;  // single_ended_zero_flag (read only)
  localparam int CTL_PACKET_DISABLE_FLAG  = 4;  // packet_disable_flag (clear only)
  localparam int CTL_ENABLE  = 3;  // module_enable
  localparam int CTL_RESUME  = 2;  // resume signalling
  localparam int CTL_SUSPEND = 1;  // suspend_ctrl

  // ------------------------------------------------------------
  // Config register fields
  // ------------------------------------------------------------
  localparam int CFG_EYE     = 7;  // eye_test_enable
  localparam int CFG_PULLUP  = 4;  // pullup_enable
  localparam int CFG_FS      = 2;  // full_speed_select
  localparam int CFG_PPB_LSB = 0;  // pingpong_mode_field, two bits

  // Events register fields
  localparam int EVT_TRN     = 0;  // transaction_done_flag
  localparam int EVT_PLL     = 1;  // pll_ready_flag mirror

  // ------------------------------------------------------------
  // Reset values and sizes
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [1:0] PPB_NONE    = 2'h0;  // no ping-pong buffering
  localparam int         NUM_BD      = 32;    // descriptor pointer bits
  localparam int         FIFO_DEPTH  = 4;     // status FIFO entries
  localparam logic [2:0] FIFO_FULL   = 3'h4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int EYE_FS_NS        = 83;   // one full-speed bit, rounded down
  localparam int EYE_LS_NS        = 666;  // one low-speed bit, rounded down
  localparam int EYE_FS_CYC       = (EYE_FS_NS * CLK_MHZ) / 1000;
  localparam int EYE_LS_CYC       = (EYE_LS_NS * CLK_MHZ) / 1000;

  // Line states driven to the transceiver
  typedef enum logic [1:0] {LINE_IDLE, LINE_J, LINE_K, LINE_SE0} line_e;

endpackage

// ===== usb_status_fifo.sv
// Four-entry transfer status FIFO read through the status window
`timescale 1ns/10ps
`default_nettype none
module usb_status_fifo
  import usb_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // Push side from the engine
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  // Advance from firmware clearing the done flag
  input  wire logic       pop,
  // Head of queue
  output logic      [7:0] head,
  output logic            not_empty,
  output logic            full
);

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;  // Entries
    logic [1:0]                 rd;   // Read pointer
    logic [1:0]                 wr;   // Write pointer
    logic [2:0]                 cnt;  // Fill level
  } fifo_s;

  fifo_s st_r;
  fifo_s st_nxt;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Push is refused when full; the engine answers the host with NAK then
  always_comb begin
    logic do_push;
    logic do_pop;
    st_nxt  = st_r;
    do_push = push && (st_r.cnt != FIFO_FULL);
    do_pop  = pop && (st_r.cnt != 3'h0);
    if (do_push) begin
      st_nxt.mem[st_r.wr] = push_data;
      st_nxt.wr           = st_r.wr + 2'h1;
    end
    if (do_pop) begin
      st_nxt.rd = st_r.rd + 2'h1;
    end
    st_nxt.cnt = st_r.cnt + {2'h0, do_push} - {2'h0, do_pop};
  end

  // Register the state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign head      = st_r.mem[st_r.rd];
  assign not_empty = (st_r.cnt != 3'h0);
  assign full      = (st_r.cnt == FIFO_FULL);

endmodule
`default_nettype wire

// ===== usb_eye_gen.sv
// Eye-pattern J/K toggler for the transceiver test mode
`timescale 1ns/10ps
`default_nettype none
module usb_eye_gen
  import usb_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Control
  input  wire logic run,
  input  wire logic full_speed,
  // Pattern out: high means K, low means J
  output logic      sym_k
);

  typedef struct packed {
    logic [7:0] cnt;  // Bit-time counter
    logic       k;    // Current symbol
    logic       on;   // Pattern has started
  } eye_s;

  eye_s st_r;
  eye_s st_nxt;

  // ------------------------------------------------------------
  // Symbol timing
  // ------------------------------------------------------------
  // Low speed starts on J, full speed on K; restarts whenever run drops.
  // Speed and run may change on the same write, so the first symbol is
  // taken from the live speed bit rather than from a stale register.
  always_comb begin
    logic [7:0] last;
    last   = full_speed ? 8'(EYE_FS_CYC - 1) : 8'(EYE_LS_CYC - 1);
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = 8'h00;
      st_nxt.k   = full_speed;
      st_nxt.on  = 1'b0;
    end else if (!st_r.on) begin
      // First cycle of the pattern counts as the first bit-time cycle
      st_nxt.cnt = 8'h01;
      st_nxt.k   = full_speed;
      st_nxt.on  = 1'b1;
    end else if (st_r.cnt >= last) begin
      st_nxt.cnt = 8'h00;
      st_nxt.k   = !st_r.k;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  // Register the state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Before start the live speed bit picks the opening symbol
  assign sym_k = st_r.on ? st_r.k : full_speed;

endmodule
`default_nettype wire

// ===== usb_ctl_properties.sv
// Concurrent checks on the ports of the USB control block
`timescale 1ns/10ps
`default_nettype none
module usb_ctl_checker
  import usb_ctl_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // Register port
  input wire logic [3:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  // Engine and transceiver side
  input wire logic              setup_token,
  input wire logic              engine_en,
  input wire logic              engine_clk_en,
  input wire logic              packets_en,
  input wire logic [NUM_BD-1:0] pp_pointer,
  input wire logic              xcvr_en,
  input wire logic              xcvr_suspend,
  input wire logic              pullup_on
);
  // ------------------------------------------------------------
  // One domain, so clock and reset are given once
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ptr_clear_a: assert property ($rose(engine_en) |-> pp_pointer == '0)
    else $error("pointer bits not cleared on enable");
  pullup_gate_a: assert property (pullup_on |-> engine_en)
    else $error("pull-ups on while module disabled");
  xcvr_follow_a: assert property (xcvr_en == engine_en)
    else $error("transceiver enable differs from module enable");
  clock_gate_a: assert property (engine_clk_en |-> engine_en && !xcvr_suspend)
    else $error("engine clock running while suspended or disabled");
  suspend_hold_a: assert property (xcvr_suspend |-> xcvr_en && !engine_clk_en)
    else $error("suspend without attached idle transceiver");
  setup_stop_a: assert property (setup_token && engine_en |-> ##[1:2] !packets_en)
    else $error("packets still enabled after setup token");
  pkt_set_ignored_a: assert property (reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[CTL_PACKET_DISABLE_FLAG]
    && reg_wdata[CTL_ENABLE] && packets_en && !setup_token |-> ##2 packets_en)
    else $error("writing one disabled packets");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the read slot");
endmodule
`default_nettype wire

// ===== usb_engine_model.sv
// Engine-side stand-in that raises SIE events into the control block
`timescale 1ns/10ps
`default_nettype none
module usb_engine_model
  import usb_ctl_pkg::*;
(
  // Clock and status from the block
  input  wire logic              clk,
  input  wire logic              trn_fifo_full,
  // Events into the block
  output logic                   setup_token,
  output logic                   trn_push,
  output logic      [7:0]        trn_status,
  output logic                   line_se0,
  output logic                   pll_ready,
  output logic      [NUM_BD-1:0] pp_toggle
);
  // Idle levels; PLL lock comes late so firmware must wait
  initial begin
    setup_token = 1'b0;
    trn_push    = 1'b0;
    trn_status  = 8'h00;
    line_se0    = 1'b0;
    pll_ready   = 1'b0;
    pp_toggle   = '0;
    repeat (30) @(posedge clk);
    pll_ready <= 1'b1;
  end

  // Pulse helper; waits until registered outputs settle
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic setup;
    @(posedge clk);
    setup_token <= 1'b1;
    @(posedge clk);
    setup_token <= 1'b0;
    settle;
  endtask

  task automatic push(input logic [7:0] d);
    @(posedge clk);
    if (!trn_fifo_full) begin
      trn_push   <= 1'b1;
      trn_status <= d;
      @(posedge clk);
      trn_push   <= 1'b0;
      // Stale data is not left on the bus
      trn_status <= ~d;
    end
    settle;
  endtask

  task automatic flip(input logic [NUM_BD-1:0] m);
    @(posedge clk);
    pp_toggle <= m;
    @(posedge clk);
    pp_toggle <= '0;
    settle;
  endtask

  task automatic se0(input logic v);
    @(posedge clk);
    line_se0 <= v;
    settle;
  endtask
endmodule
`default_nettype wire

// ===== usb_ctl_top_test.sv
// Self-checking bench for the USB control block
`timescale 1ns/10ps
`default_nettype none
module usb_ctl_top_test
  import usb_ctl_pkg::*;
;
  logic clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, trn_status;
  logic setup_token, trn_push, line_se0, pll_ready, engine_en, engine_clk_en;
  logic packets_en, trn_fifo_full, xcvr_en, xcvr_full_speed, xcvr_suspend;
  logic pullup_on, line_drive;
  logic [1:0] line_state;
  logic [NUM_BD-1:0] pp_pointer, pp_toggle;
  int fails = 0, comparisons = 0;

  always #5 clk = ~clk;

  usb_ctl_top u_usb_ctl_top (.clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .setup_token, .trn_push, .trn_status, .line_se0, .pll_ready, .engine_en,
    .engine_clk_en, .packets_en, .trn_fifo_full, .pp_pointer, .pp_toggle, .xcvr_en,
    .xcvr_full_speed, .xcvr_suspend, .pullup_on, .line_drive, .line_state);
  usb_engine_model u_usb_engine_model (.clk, .trn_fifo_full, .setup_token, .trn_push,
    .trn_status, .line_se0, .pll_ready, .pp_toggle);

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register write; returns once control outputs have followed
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Register read; data is only valid in the slot after the strobe
  task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask

  task automatic t_reset;
    rd(ADDR_CONTROL, CONTROL_RST, "control");
    rd(ADDR_CONFIG, CONFIG_RST, "config");
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, "unmapped");
  endtask

  task automatic t_enable;
    wr(ADDR_CONFIG, 8'h15);
    wr(ADDR_CONTROL, 8'h08);
    chk("pp_pointer", pp_pointer, 0);
    chk("pullup_on", pullup_on, 1);
    chk("xcvr_en", xcvr_en, 1);
    chk("full_speed", xcvr_full_speed, 1);
    u_usb_engine_model.flip(32'h0000_00a5);
    chk("pp flip", pp_pointer, 32'h0000_00a5);
    wr(ADDR_CONTROL, 8'h48);
    chk("pp reset", pp_pointer, 0);
    u_usb_engine_model.flip(32'h0000_0003);
    chk("pp held", pp_pointer, 0);
    // Firmware releases the pointer reset itself
    wr(ADDR_CONTROL, 8'h08);
    u_usb_engine_model.flip(32'h0000_0003);
    chk("pp free", pp_pointer, 32'h0000_0003);
    wr(ADDR_CONFIG, 8'h14);
    wr(ADDR_CONTROL, 8'h48);
    chk("pp ignored", pp_pointer, 32'h0000_0003);
    wr(ADDR_CONFIG, 8'h00);
    chk("pullup bit", pullup_on, 0);
    chk("low speed", xcvr_full_speed, 0);
    wr(ADDR_CONFIG, 8'h10);
    wr(ADDR_CONTROL, 8'h00);
    chk("detach", pullup_on, 0);
  endtask

  task automatic t_pkt;
    wr(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h18);
    chk("pkt set ignored", packets_en, 1);
    u_usb_engine_model.setup();
    chk("pkt off", packets_en, 0);
    rd(ADDR_CONTROL, 8'h18, "pkt flag");
    wr(ADDR_CONTROL, 8'h08);
    chk("pkt on", packets_en, 1);
  endtask

  task automatic t_fifo;
    for (int i = 0; i < 5; i++) u_usb_engine_model.push(8'h30 + 8'(i));
    chk("fifo full", trn_fifo_full, 1);
    rd(ADDR_EVENTS, 8'h03, "events");
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_STATUS, 8'h30 + 8'(i), "fifo head");
      wr(ADDR_EVENTS, 8'h00);
    end
    rd(ADDR_EVENTS, 8'h02, "events empty");
  endtask

  task automatic t_line;
    u_usb_engine_model.se0(1'b1);
    rd(ADDR_CONTROL, 8'h28, "se0 seen");
    u_usb_engine_model.se0(1'b0);
    rd(ADDR_CONTROL, 8'h08, "se0 gone");
    // suspend entered only from an idle bus
    wr(ADDR_CONTROL, 8'h0a);
    chk("clk gated", engine_clk_en, 0);
    chk("attached", pullup_on, 1);
    chk("idle out", line_drive, 0);
    wr(ADDR_CONTROL, 8'h08);
    chk("clk back", engine_clk_en, 1);
    // Resume held short here; the real 10 ms is firmware timing
    wr(ADDR_CONTROL, 8'h0c);
    chk("resume K", {line_drive, line_state}, {1'b1, LINE_K});
    wr(ADDR_CONTROL, 8'h08);
    chk("resume end", line_drive, 0);
  endtask

  // Eye pattern: first symbol, the swap, then one full bit later
  task automatic eye_run(logic [7:0] cfg, logic [1:0] first, int cyc);
    int n;
    wr(ADDR_CONFIG, cfg);
    chk("eye first", {line_drive, line_state}, {1'b1, first});
    n = 0;
    while (line_state === first && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("eye swap", line_state, first ^ 2'b11);
    repeat (cyc) @(posedge clk);
    #1 chk("eye again", line_state, first);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    while (!pll_ready) @(posedge clk);
    t_enable;
    t_pkt;
    t_fifo;
    t_line;
    eye_run(8'h94, LINE_K, EYE_FS_CYC);
    wr(ADDR_CONFIG, 8'h10);
    eye_run(8'h90, LINE_J, EYE_LS_CYC);
    wr(ADDR_CONTROL, 8'h00);
    chk("eye needs enable", line_drive, 0);
    tally_and_finish;
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #200_000;
    fails++;
    tally_and_finish;
  end
endmodule

bind usb_ctl_top usb_ctl_checker u_usb_ctl_checker (.clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .setup_token, .engine_en, .engine_clk_en, .packets_en,
  .pp_pointer, .xcvr_en, .xcvr_suspend, .pullup_on);
`default_nettype wire
